// ===== adc_control_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 25 MHz bus clock, word-aligned register indices
// Notes: Byte address of a register is four times its index
//
// Overview of operation
// RULE1: Completion loads result, clears go, sets flag
// RULE2: Software waits acquisition time before starting
// RULE3: Software sets analog pins as inputs
// RULE4: Software follows configure, wait, go, poll, read
// RULE5: Pin config code selects analog pins, reference
// RULE6: Channel field routes one input to hold
// RULE7: Clock field divides oscillator by 2, 8, 32
// RULE8: Converter-on bit powers converter; off never converts
// RULE9: Successive approximation yields eight-bit result
// RULE10: Each conversion lasts nine and half bit periods
// RULE11: Software waits two bit periods after completion
// RULE12: Writing go starts the conversion
// RULE13: Go write ignored while converter is off
`ifndef ADC_CONTROL_DEFINES_SVH
`define ADC_CONTROL_DEFINES_SVH

// ==========================================================
// Register indices
`define CTRL_IDX 10'h01F
`define PINCFG_IDX 10'h09F
`define RESULT_IDX 10'h01E
`define IRQ_STAT_IDX 10'h020
`define IRQ_CLR_IDX 10'h021
`define IRQ_EN_IDX 10'h022

// ==========================================================
// Field positions
`define CTRL_ON_BIT 0
`define CTRL_GO_BIT 2
`define CTRL_CHAN_LO 3
`define CTRL_CLK_LO 6
`define IRQ_DONE_BIT 0

// ==========================================================
// Reset values
`define CTRL_RESET 8'h00
`define PINCFG_RESET 2'h0
`define RESULT_RESET 8'h00

// ==========================================================
// Timing
`define CLK_PERIOD_NS 40
`define RC_TAD_NS 4000
`define RC_HALF_CYCLES (`RC_TAD_NS / `CLK_PERIOD_NS / 2)
`define HALF_TICKS_LAST 5'h12

`endif

// ===== adc_types_pkg.sv
// Purpose: Types shared by the converter control block
// Assumes: Used by scoped name only
// Notes: None
package adc_types_pkg;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [1:0] chan;
    logic go;
    logic on;
  } ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;

endpackage

// ===== adc_control.sv
// Purpose: Eight-bit successive approximation converter control
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: Analog inputs arrive as eight-bit digital levels
`timescale 1ns/1ps
`include "adc_control_defines.svh"

module adc_control #(
  parameter logic [7:0] RC_HALF = 8'(`RC_HALF_CYCLES)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0][7:0] analog_in,
  output logic [3:0] analog_pins,
  output logic ref_from_pin3,
  output logic converter_powered,
  output logic [1:0] sh_channel,
  output logic irq
);

  adc_types_pkg::ctrl_t ctrl;
  adc_types_pkg::conv_state_t state;
  logic [1:0] pin_config;
  logic [7:0] result;
  logic irq_status;
  logic irq_enable;
  logic wr_pend;
  logic [9:0] wr_idx;
  logic [7:0] wd;
  logic wr_ctrl;
  logic go_req;
  logic abort;
  logic busy;
  logic [7:0] div_cnt;
  logic [7:0] half_div;
  logic tick;
  logic [4:0] half_cnt;
  logic [4:0] bits_left;
  logic [2:0] bit_idx;
  logic decide;
  logic [7:0] trial;
  logic [7:0] sample;
  logic [7:0] approx;
  logic done_pulse;
  logic [7:0] read_val;
  logic unused_bits;
  logic [12:0] busy_len;
  logic [7:0] tick_gap;

  localparam logic [7:0] CTRL_RST = `CTRL_RESET;

  // ========================================================
  // Bus capture and decode
  assign unused_bits = ^{hsize, haddr[31:12], haddr[1:0], hwdata[31:8]};
  assign wd = hwdata[7:0];
  assign wr_ctrl = wr_pend && (wr_idx == `CTRL_IDX);
  assign busy = (state == adc_types_pkg::ST_CONV);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 10'h000;
    end else begin
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      wr_idx <= haddr[11:2];
    end
  end

  always_comb begin
    read_val = 8'h00;
    case (haddr[11:2])
      `CTRL_IDX: read_val = {ctrl.clk_sel, 1'b0, ctrl.chan, ctrl.go,
                             1'b0, ctrl.on};
      `PINCFG_IDX: read_val = {6'h00, pin_config};
      `RESULT_IDX: read_val = result;
      `IRQ_STAT_IDX: read_val = {7'h00, irq_status};
      `IRQ_EN_IDX: read_val = {7'h00, irq_enable};
      default: read_val = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hsel && htrans[1] && hready && !hwrite) begin
        hrdata <= {24'h00_0000, read_val};
      end
    end
  end

  // ========================================================
  // Control and pin configuration registers
  assign go_req = wr_ctrl && wd[`CTRL_GO_BIT] && wd[`CTRL_ON_BIT] &&
                  ctrl.on && !busy; // RULE13 RULE12
  assign abort = busy && (!ctrl.on || (wr_ctrl && !wd[`CTRL_GO_BIT])); // RULE8

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= '{clk_sel: CTRL_RST[`CTRL_CLK_LO +: 2],
                chan: CTRL_RST[`CTRL_CHAN_LO +: 2],
                go: CTRL_RST[`CTRL_GO_BIT],
                on: CTRL_RST[`CTRL_ON_BIT]};
    end else begin
      if (wr_ctrl) begin
        ctrl.clk_sel <= wd[`CTRL_CLK_LO +: 2];
        ctrl.chan <= wd[`CTRL_CHAN_LO +: 2];
        ctrl.on <= wd[`CTRL_ON_BIT]; // RULE8
      end
      if (done_pulse || abort) begin
        ctrl.go <= 1'b0; // RULE1
      end else if (go_req) begin
        ctrl.go <= 1'b1; // RULE12
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_config <= `PINCFG_RESET;
    end else if (wr_pend && wr_idx == `PINCFG_IDX) begin
      pin_config <= wd[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_pins <= 4'h0;
      ref_from_pin3 <= 1'b0;
      converter_powered <= 1'b0;
      sh_channel <= 2'h0;
    end else begin
      case (pin_config)
        2'h0: analog_pins <= 4'hF; // RULE5
        2'h1: analog_pins <= 4'h7; // RULE5
        2'h2: analog_pins <= 4'h3; // RULE5
        default: analog_pins <= 4'h0; // RULE5
      endcase
      ref_from_pin3 <= (pin_config == 2'h1); // RULE5
      converter_powered <= ctrl.on; // RULE8
      sh_channel <= ctrl.chan; // RULE6
    end
  end

  // ========================================================
  // Conversion clock divider, half bit period ticks
  always_comb begin
    case (ctrl.clk_sel)
      2'h0: half_div = 8'h01; // RULE7
      2'h1: half_div = 8'h04; // RULE7
      2'h2: half_div = 8'h10; // RULE7
      default: half_div = RC_HALF;
    endcase
  end

  assign tick = busy && (div_cnt >= half_div - 8'h01);

  // ========================================================
  // Successive approximation engine
  assign bits_left = 5'h11 - half_cnt;
  assign bit_idx = bits_left[3:1];
  assign decide = half_cnt[0] && (half_cnt >= 5'h03) && (half_cnt <= 5'h11);
  assign trial = approx | (8'h01 << bit_idx);
  assign done_pulse = tick && (half_cnt == `HALF_TICKS_LAST) && !abort;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= adc_types_pkg::ST_IDLE;
      div_cnt <= 8'h00;
      half_cnt <= 5'h00;
      sample <= 8'h00;
      approx <= 8'h00;
    end else begin
      case (state)
        adc_types_pkg::ST_IDLE: begin
          if (go_req) begin
            state <= adc_types_pkg::ST_CONV; // RULE12
            div_cnt <= 8'h00;
            half_cnt <= 5'h00;
            sample <= analog_in[wd[`CTRL_CHAN_LO +: 2]]; // RULE6
            approx <= 8'h00;
          end
        end
        adc_types_pkg::ST_CONV: begin
          if (abort || done_pulse) begin
            state <= adc_types_pkg::ST_IDLE; // RULE10
          end else if (tick) begin
            div_cnt <= 8'h00;
            half_cnt <= half_cnt + 5'h01; // RULE10
            if (decide && sample >= trial) begin
              approx <= trial; // RULE9
            end
          end else begin
            div_cnt <= div_cnt + 8'h01;
          end
        end
        default: state <= adc_types_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= `RESULT_RESET;
    end else if (done_pulse) begin
      result <= approx; // RULE1 RULE9
    end
  end

  // ========================================================
  // Interrupt status, clear and enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 1'b0;
      irq_enable <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (done_pulse) begin
        irq_status <= 1'b1; // RULE1
      end else if (wr_pend && wr_idx == `IRQ_CLR_IDX &&
                   wd[`IRQ_DONE_BIT]) begin
        irq_status <= 1'b0;
      end
      if (wr_pend && wr_idx == `IRQ_EN_IDX) begin
        irq_enable <= wd[`IRQ_DONE_BIT];
      end
      irq <= irq_status && irq_enable;
    end
  end

  // ========================================================
  // Helper counters for the checks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_len <= 13'h0000;
      tick_gap <= 8'h00;
    end else begin
      busy_len <= busy ? busy_len + 13'h0001 : 13'h0000;
      tick_gap <= (busy && !tick) ? tick_gap + 8'h01 : 8'h00;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_fast_done;
    done_pulse ##1 (!busy && !ctrl.go);
  endsequence

  chk_done_event: assert property (done_pulse |=> // RULE1
    !ctrl.go && irq_status && result == $past(approx))
    else $error("completion did not update go, flag and result");
  chk_pin_map: assert property (pin_config == 2'h2 |=> // RULE5
    analog_pins == 4'h3 && !ref_from_pin3)
    else $error("pin configuration map wrong");
  chk_channel_sample: assert property (go_req |=> // RULE6
    sample == $past(analog_in[wd[`CTRL_CHAN_LO +: 2]]))
    else $error("wrong channel sampled");
  chk_div_eight: assert property ( // RULE7
    tick && ctrl.clk_sel == 2'h1 && !done_pulse && !abort |=>
    !tick [*3] ##1 tick)
    else $error("divide by eight spacing wrong");
  chk_off_idle: assert property (!ctrl.on |=> !busy) // RULE8
    else $error("converter ran while off");
  chk_sar_value: assert property (done_pulse |=> result == $past(sample)) // RULE9
    else $error("result differs from sampled level");
  chk_conv_length: assert property ( // RULE10
    busy && ctrl.clk_sel == 2'h0 && busy_len == 13'h0012 && !abort |->
    s_fast_done)
    else $error("conversion length not nineteen half periods");
  chk_fast_bound: assert property ( // RULE10
    busy && ctrl.clk_sel == 2'h0 |-> busy_len <= 13'h0012)
    else $error("conversion ran past nineteen half periods");
  chk_go_starts: assert property (go_req |=> busy && ctrl.go) // RULE12
    else $error("go write did not start conversion");
  chk_off_ignore: assert property ( // RULE13
    wr_ctrl && wd[`CTRL_GO_BIT] && !ctrl.on && !busy |=>
    !busy && !ctrl.go && $stable(result))
    else $error("go accepted while off");
  chk_div_two: assert property ( // RULE7
    tick && ctrl.clk_sel == 2'h0 && !done_pulse && !abort |=> tick)
    else $error("divide by two spacing wrong");
  chk_div_thirty_two: assert property ( // RULE7
    tick && ctrl.clk_sel == 2'h2 |-> tick_gap == 8'h0F)
    else $error("divide by thirty two spacing wrong");
  chk_pin_ref: assert property (pin_config == 2'h1 |=> // RULE5
    analog_pins == 4'h7 && ref_from_pin3)
    else $error("pin three reference map wrong");
  chk_pin_all: assert property (pin_config == 2'h0 |=> // RULE5
    analog_pins == 4'hF && !ref_from_pin3)
    else $error("all analog map wrong");
  chk_channel_out: assert property ( // RULE6
    1'b1 |=> sh_channel == $past(ctrl.chan))
    else $error("selected channel output wrong");
  chk_power_copy: assert property ( // RULE8
    1'b1 |=> converter_powered == $past(ctrl.on))
    else $error("converter power output wrong");
  chk_abort_clean: assert property (abort |=> // RULE8
    !busy && !ctrl.go && $stable(result))
    else $error("abort left conversion state behind");
  chk_irq_high: assert property ( // RULE1
    irq_status && irq_enable |=> irq)
    else $error("interrupt missing while enabled flag set");
  chk_irq_low: assert property ( // RULE1
    !irq_status || !irq_enable |=> !irq)
    else $error("interrupt high without enabled flag");
  chk_flag_clear: assert property ( // RULE1
    wr_pend && wr_idx == `IRQ_CLR_IDX && wd[`IRQ_DONE_BIT] &&
    !done_pulse |=> !irq_status)
    else $error("status clear write ignored");

endmodule

// ===== analog_src.sv
// Purpose: Analog sources on the four converter pins
// Assumes: Each level is an eight-bit value
// Notes: Levels move only when the bench changes seed
`timescale 1ns/1ps
// ==========================================================
// Source model
module analog_src (
  input wire logic [7:0] seed,
  output logic [3:0][7:0] analog_in
);
  // Levels hold steady through acquisition; pins are inputs
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      analog_in[i] = seed ^ (8'h1B + 8'(i) * 8'h44);
    end
  end
endmodule

// ===== adc_control_tb.sv
// Purpose: Self-checking bench for adc_control
// Assumes: Zero wait bus slave, RC half period set to 2
// Notes: Conversion time is nineteen half periods plus two edges
`timescale 1ns/1ps
module adc_control_tb;
  typedef struct packed {
    logic [7:0] pc, ct;
    logic [3:0] pins;
    logic rf;
    logic [1:0] ch;
    logic pw;
  } row_t;
  row_t rows [4] = '{'{8'h00, 8'h01, 4'hF, 1'b0, 2'h0, 1'b1},
    '{8'h01, 8'h08, 4'h7, 1'b1, 2'h1, 1'b0},
    '{8'h02, 8'h11, 4'h3, 1'b0, 2'h2, 1'b1},
    '{8'h03, 8'h18, 4'h0, 1'b0, 2'h3, 1'b0}};
  int hf [4] = '{1, 4, 16, 2};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic hreadyout, hresp, ref_from_pin3, converter_powered, irq;
  logic [3:0] analog_pins;
  logic [1:0] sh_channel;
  logic [3:0][7:0] analog_in;
  logic [7:0] seed = 8'h00, ex, c;
  int error_cnt = 0, num_checks = 0, cyc = 0, n;
  always #20 hclk = ~hclk;
  adc_control #(.RC_HALF(8'h02)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .analog_in(analog_in),
    .analog_pins(analog_pins), .ref_from_pin3(ref_from_pin3),
    .converter_powered(converter_powered), .sh_channel(sh_channel),
    .irq(irq));
  analog_src src (.seed(seed), .analog_in(analog_in));
  task automatic summarize;
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [9:0] a,
    input logic [7:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rst_chk;
    logic [9:0] ix [5] = '{10'h01F, 10'h09F, 10'h01E, 10'h020, 10'h022};
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    chk("pins", 32'h0, 32'(analog_pins));
    chk("powered", 32'h0, 32'(converter_powered));
    foreach (ix[i]) begin
      xfer(1'b0, ix[i], 8'h00, r);
      chk("reset value", 32'h0, r);
    end
    chk("pins", 32'hF, 32'(analog_pins));
    chk("hresp", 32'h0, 32'(hresp));
    chk("hreadyout", 32'h1, 32'(hreadyout));
  endtask
  initial begin
    rst_chk;
    foreach (rows[i]) begin
      xfer(1'b1, 10'h09F, rows[i].pc, r);
      xfer(1'b1, 10'h01F, rows[i].ct, r);
      xfer(1'b0, 10'h01F, 8'h00, r);
      chk("control", 32'(rows[i].ct), r);
      repeat (2) @(posedge hclk);
      chk("pins", 32'(rows[i].pins), 32'(analog_pins));
      chk("ref", 32'(rows[i].rf), 32'(ref_from_pin3));
      chk("channel", 32'(rows[i].ch), 32'(sh_channel));
      chk("powered", 32'(rows[i].pw), 32'(converter_powered));
    end
    xfer(1'b1, 10'h022, 8'h01, r);
    for (int s = 0; s < 4; s++) begin
      c = {s[1:0], 1'b0, s[1:0], 3'h1};
      xfer(1'b1, 10'h01F, c, r);
      repeat (8) @(posedge hclk);
      xfer(1'b1, 10'h01F, c | 8'h04, r);
      ex = seed ^ (8'h1B + 8'(s) * 8'h44);
      seed <= seed + 8'h3D;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge hclk);
        n++;
      end
      chk("conv time", 19 * hf[s] + 2, n);
      xfer(1'b0, 10'h01E, 8'h00, r);
      chk("result", 32'(ex), r);
      xfer(1'b0, 10'h01F, 8'h00, r);
      chk("go", 32'(c), r);
      xfer(1'b0, 10'h020, 8'h00, r);
      chk("status", 32'h1, r);
      xfer(1'b1, 10'h022, 8'h00, r);
      repeat (2) @(posedge hclk);
      chk("masked", 32'h0, 32'(irq));
      xfer(1'b1, 10'h022, 8'h01, r);
      repeat (2) @(posedge hclk);
      chk("unmasked", 32'h1, 32'(irq));
      xfer(1'b1, 10'h021, 8'h01, r);
      repeat (2) @(posedge hclk);
      chk("cleared", 32'h0, 32'(irq));
      repeat (4 * hf[s]) @(posedge hclk);
    end
    xfer(1'b1, 10'h01F, 8'h00, r);
    xfer(1'b1, 10'h01F, 8'h05, r);
    repeat (40) @(posedge hclk);
    chk("go when off", 32'h0, 32'(irq));
    xfer(1'b0, 10'h01F, 8'h00, r);
    chk("go when off", 32'h1, r);
    xfer(1'b1, 10'h01F, 8'h05, r);
    xfer(1'b1, 10'h01F, 8'h00, r);
    repeat (60) @(posedge hclk);
    chk("abort", 32'h0, 32'(irq));
    xfer(1'b0, 10'h020, 8'h00, r);
    chk("abort status", 32'h0, r);
    xfer(1'b0, 10'h01E, 8'h00, r);
    chk("result kept", 32'(ex), r);
    xfer(1'b1, 10'h100, 8'hFF, r);
    xfer(1'b0, 10'h100, 8'h00, r);
    chk("unmapped", 32'h0, r);
    xfer(1'b0, 10'h021, 8'h00, r);
    chk("clear reads", 32'h0, r);
    rst_chk;
    summarize;
  end
endmodule
